// ---- bench/gauge_i2c_assertions.sv ----
// Port checker for the gauge two-wire target engine
`include "gauge_i2c_consts.svh"

module gauge_i2c_checker #(
  parameter int unsigned TIMEOUT_CYC = `STUCK_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // Bus pins
  input wire logic       scl_i, scl_o, scl_oe_n,
  input wire logic       sda_i, sda_o, sda_oe_n,
  // Location port and status
  input wire logic [7:0] loc_addr, loc_wdata, loc_rdata,
  input wire logic       loc_wr, loc_ro, eng_sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Helper state
  logic [31:0] low_ff;   // Cycles with a line low
  logic [31:0] nxt_low;
  logic [7:0]  wa_ff;    // Address of last write
  logic [7:0]  nxt_wa;
  // Saturating count, so a long stall cannot wrap it
  always_comb begin
    nxt_low = low_ff;
    nxt_wa  = loc_wr ? loc_addr : wa_ff;
    if (scl_i && sda_i) begin
      nxt_low = '0;
    end else if (low_ff < TIMEOUT_CYC + 8) begin
      nxt_low = low_ff + 1;
    end
  end
  // Register helper state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_ff <= '0;
      wa_ff  <= 8'h00;
    end else begin
      low_ff <= nxt_low;
      wa_ff  <= nxt_wa;
    end
  end
  // ==========================================================
  // Properties
  AST_SCL_NEVER_HELD: assert property (scl_oe_n)
    else $error("target drove the clock line");
  AST_DRIVE_LOW_ONLY: assert property (!sda_o && !scl_o)
    else $error("pin drive value not low");
  AST_WR_ONE_CYCLE: assert property (loc_wr |=> !loc_wr)
    else $error("write strobe longer than one cycle");
  AST_RO_NEVER_WRITTEN: assert property (loc_wr |-> !loc_ro)
    else $error("read-only location written");
  AST_WR_PTR_ADVANCE: assert property (
    loc_wr |=> ##[0:60] (loc_addr == wa_ff + 8'h01))
    else $error("pointer did not advance after write");
  AST_SLEEP_QUIET: assert property (eng_sleep |-> sda_oe_n && !loc_wr)
    else $error("sleeping engine still active");
  AST_STUCK_RELEASE: assert property (
    (low_ff == TIMEOUT_CYC + 8) |-> sda_oe_n)
    else $error("data line held past stuck timeout");
  AST_DRIVE_SCL_LOW: assert property ($fell(sda_oe_n) |-> !scl_i)
    else $error("data line taken while clock high");
endmodule : gauge_i2c_checker

bind fuel_gauge_i2c_target gauge_i2c_checker #(
  .TIMEOUT_CYC(TIMEOUT_CYC)
) i_gauge_i2c_checker (
  .sys_clk(sys_clk), .nrst(nrst), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_rdata(loc_rdata),
  .loc_wr(loc_wr), .loc_ro(loc_ro), .eng_sleep(eng_sleep)
);

// ---- bench/host_bfm.sv ----
// Bus master model that drives the target over the two wires
module host_bfm #(
  parameter int Q = 8
) (
  // Clock and target enables
  input  wire logic sys_clk,
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  // Resolved wire levels
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_scl = 1'b1;  // Master clock drive, idles high
  logic m_sda = 1'b1;  // Master data drive, idles high
  // Pulled-up wires: any party enabling pulls low
  assign scl = m_scl & scl_oe_n;
  assign sda = m_sda & sda_oe_n;
  // Wait whole clock cycles
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // Data moves inside the low phase, clear of clock edges
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    m_sda <= b;
    wt(Q);
    m_scl <= 1'b1;
    wt(Q);
    r = sda;
    m_scl <= 1'b0;
  endtask : bit_io
  // Start or repeated start: data falls while clock high
  task automatic start();
    wt(2);
    m_sda <= 1'b1;
    wt(Q);
    m_scl <= 1'b1;
    wt(Q);
    m_sda <= 1'b0;
    wt(Q);
    m_scl <= 1'b0;
  endtask : start
  // Stop: data rises while clock high
  task automatic stop();
    wt(2);
    m_sda <= 1'b0;
    wt(Q);
    m_scl <= 1'b1;
    wt(Q);
    m_sda <= 1'b1;
    wt(Q);
  endtask : stop
  // Byte out, MSB first; ack is the target pulling low
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr
  // Byte in; last byte closed by nack before stop
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask : rd
endmodule : host_bfm

// ---- bench/tb_top.sv ----
// Self-checking testbench for the gauge two-wire target engine
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 2000;  // Short stuck-low limit
  logic       sys_clk, nrst, scl, sda, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic       loc_wr, loc_ro, eng_sleep;
  logic [7:0] loc_addr, loc_wdata, loc_rdata;
  logic [7:0] mem [256];  // Command location store
  int         n_errors, total_checks;
  // Location 10 is the read-only one
  assign loc_rdata = mem[loc_addr];
  assign loc_ro    = (loc_addr == 8'h10);
  always @(posedge sys_clk) if (loc_wr) mem[loc_addr] <= loc_wdata;
  fuel_gauge_i2c_target #(.TIMEOUT_CYC(TMO), .MAX_WBYTES(2))
    i_fuel_gauge_i2c_target (
    .sys_clk(sys_clk), .nrst(nrst), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_wr(loc_wr),
    .loc_rdata(loc_rdata), .loc_ro(loc_ro), .eng_sleep(eng_sleep));
  host_bfm i_host_bfm (.sys_clk(sys_clk), .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  // ==========================================================
  // Helpers
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic wa(input logic [7:0] d, input logic ea, input string w);
    logic a;
    i_host_bfm.wr(d, a);
    chk(w, {7'h00, ea}, {7'h00, a});
  endtask : wa
  task automatic ra(input logic mack, input logic [7:0] e, input string w);
    logic [7:0] d;
    i_host_bfm.rd(mack, d);
    chk(w, e, d);
  endtask : ra
  // ==========================================================
  // Scenarios
  task automatic t_write();
    i_host_bfm.start();
    wa(8'hAA, 1'b1, "write addr ack");
    wa(8'h20, 1'b1, "cmd ack");
    wa(8'h3C, 1'b1, "data0 ack");
    wa(8'h5A, 1'b1, "data1 ack");
    wa(8'h99, 1'b0, "surplus ack");
    wa(8'h98, 1'b0, "surplus2 ack");
    i_host_bfm.stop();
    chk("loc20", 8'h3C, mem[8'h20]);
    chk("loc21", 8'h5A, mem[8'h21]);
    chk("loc22", 8'h22, mem[8'h22]);
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    i_host_bfm.start();
    wa(8'hA8, 1'b0, "foreign addr ack");
    i_host_bfm.stop();
    i_host_bfm.start();
    wa(8'hAA, 1'b1, "addr ack");
    wa(8'h20, 1'b1, "cmd ack");
    i_host_bfm.start();
    wa(8'hAB, 1'b1, "read addr ack");
    ra(1'b1, 8'h3C, "read byte0");
    ra(1'b0, 8'h5A, "read byte1");
    i_host_bfm.stop();
    i_host_bfm.start();
    wa(8'hAB, 1'b1, "quick addr ack");
    ra(1'b0, 8'h5A, "quick byte");
    i_host_bfm.stop();
    $display("test read done");
  endtask : t_read
  task automatic t_refuse();
    i_host_bfm.start();
    wa(8'hAA, 1'b1, "addr ack");
    wa(8'h10, 1'b1, "ro cmd ack");
    wa(8'h77, 1'b0, "ro data ack");
    i_host_bfm.stop();
    chk("loc10", 8'h10, mem[8'h10]);
    i_host_bfm.start();
    wa(8'hAB, 1'b1, "stuck addr ack");
    i_host_bfm.wt(4);
    chk("drive bit7", 8'h00, {7'h00, sda_oe_n});
    i_host_bfm.wt(TMO + 40);
    chk("released", 8'h01, {7'h00, sda_oe_n});
    chk("asleep", 8'h01, {7'h00, eng_sleep});
    i_host_bfm.stop();
    chk("awake", 8'h00, {7'h00, eng_sleep});
    i_host_bfm.start();
    wa(8'hAA, 1'b1, "addr ack");
    wa(8'h7F, 1'b1, "top cmd ack");
    i_host_bfm.start();
    wa(8'hAA, 1'b1, "addr ack");
    wa(8'h80, 1'b0, "high cmd ack");
    i_host_bfm.stop();
    $display("test refuse done");
  endtask : t_refuse
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    n_errors = 0;
    total_checks = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i);
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_write();
    t_read();
    t_refuse();
    report_and_stop();
  end
endmodule : tb_top

// ---- core/bus_stuck_low_timeout.sv ----
// Stuck-low watchdog for the two-wire bus lines
`include "gauge_i2c_consts.svh"

module bus_stuck_low_timeout #(
  parameter int unsigned TIMEOUT_CYC = `STUCK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Line level
  input  wire logic line_low,
  // Result
  output logic      expired
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

  logic [CW-1:0] cnt_ff;      // Cycles the bus has been low
  logic [CW-1:0] nxt_cnt;
  logic          exp_ff;      // Timeout reached, held while low
  logic          nxt_exp;

  // ========================================================
  // Count while low; any high level clears it
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_exp = exp_ff;
    if (!line_low) begin
      nxt_cnt = '0;
      nxt_exp = 1'b0;
    end else if (cnt_ff >= CW'(TIMEOUT_CYC - 1)) begin
      nxt_exp = 1'b1;      // Saturate rather than wrap
    end else begin
      nxt_cnt = cnt_ff + CW'(1);
    end
  end

  // Register stage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

  assign expired = exp_ff;

endmodule : bus_stuck_low_timeout

// ---- core/fuel_gauge_i2c_target.sv ----
// Two-wire bus target engine for the gauge command locations
`include "gauge_i2c_consts.svh"

// ==========================================================
// Bus timing as this engine sees it
// - Both pins are sampled once per system clock, so the host
//   must hold each level for a few cycles
// - Bits are taken on a rising serial clock and a byte is
//   judged on the falling edge that closes its eighth bit
// - Our own data changes one cycle after a falling clock,
//   well inside the low phase
// - The serial clock is never stretched; a slow location
//   port would need a wait scheme this block does not have

module fuel_gauge_i2c_target #(
  parameter int unsigned TIMEOUT_CYC = `STUCK_TIMEOUT_CYC,
  parameter int unsigned MAX_WBYTES  = 2
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Serial clock pin (open drain; oe low means drive low)
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n,
  // Serial data pin (open drain; oe low means drive low)
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // Command location port
  output logic [7:0]      loc_addr,
  output logic [7:0]      loc_wdata,
  output logic            loc_wr,
  input  wire logic [7:0] loc_rdata,
  input  wire logic       loc_ro,
  // Status
  output logic            eng_sleep
);

  localparam int WCW = $clog2(MAX_WBYTES + 2);

  // ========================================================
  // Pin history for edge and condition detection
  logic scl_d_ff, sda_d_ff;       // Previous line levels
  logic nxt_scl_d, nxt_sda_d;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Capture this cycle's levels
  always_comb begin
    nxt_scl_d = scl_i;
    nxt_sda_d = sda_i;
  end

  // Idle high after reset, so reset makes no false edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= nxt_scl_d;
      sda_d_ff <= nxt_sda_d;
    end
  end

  // Start: data falls while clock high; stop: data rises
  assign scl_rise = scl_i & ~scl_d_ff;
  assign scl_fall = ~scl_i & scl_d_ff;
  assign start_c  = scl_i & scl_d_ff & sda_d_ff & ~sda_i;
  assign stop_c   = scl_i & scl_d_ff & ~sda_d_ff & sda_i;

  // ========================================================
  // Stuck-low watchdog; either line low counts
  // The count restarts whenever both lines are high, so
  // normal traffic with its high phases never nears it
  logic tmo;

  bus_stuck_low_timeout #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_tmo (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .line_low (~scl_i | ~sda_i),
    .expired  (tmo)
  );

  // ========================================================
  // Engine state
  gauge_i2c_pkg::eng_state_t st_ff, nxt_st;
  logic [7:0]     sh_ff, nxt_sh;        // Shift register
  logic [2:0]     bit_ff, nxt_bit;      // Bit count in byte
  logic [7:0]     ptr_ff, nxt_ptr;      // Address pointer
  logic           rw_ff, nxt_rw;        // Read direction
  logic           ack_ff, nxt_ack;      // Ack this slot, ours or the master's on read
  logic [WCW-1:0] wcnt_ff, nxt_wcnt;    // Data bytes taken
  logic           sda_lo_ff, nxt_sda_lo; // Drive data low
  logic           wr_ff, nxt_wr;        // Location write pulse
  logic [7:0]     wd_ff, nxt_wd;        // Location write data
  logic           slp_ff, nxt_slp;      // Sleep indication
  logic           full_ff, nxt_full;    // Eight bits shifted in
  logic           sda_oe_n_ff, nxt_sda_oe_n; // Pin enable, low drives

  // Next-state logic for the whole bus engine
  always_comb begin
    nxt_st     = st_ff;
    nxt_sh     = sh_ff;
    nxt_bit    = bit_ff;
    nxt_ptr    = ptr_ff;
    nxt_rw     = rw_ff;
    nxt_ack    = ack_ff;
    nxt_wcnt   = wcnt_ff;
    nxt_sda_lo = sda_lo_ff;
    nxt_wr     = 1'b0;
    nxt_wd     = wd_ff;
    nxt_slp    = slp_ff;
    nxt_full   = full_ff;
    // Sleep once per timeout; a sleeping engine must still
    // see the start or stop that wakes it
    if (tmo && st_ff != gauge_i2c_pkg::ST_SLEEP) begin
      // Let go of the data line; the clock is never held, so anything still low is external
      nxt_sda_lo = 1'b0;
      nxt_st     = gauge_i2c_pkg::ST_SLEEP;
      nxt_slp    = 1'b1;
      nxt_full   = 1'b0;
    end else if (start_c) begin
      // Start or repeated start: new address byte
      nxt_st     = gauge_i2c_pkg::ST_ADDR;
      nxt_bit    = 3'h0;
      nxt_sda_lo = 1'b0;
      nxt_slp    = 1'b0;
      nxt_full   = 1'b0;
    end else if (stop_c) begin
      nxt_st     = gauge_i2c_pkg::ST_IDLE;
      nxt_sda_lo = 1'b0;
      nxt_slp    = 1'b0;
    end else begin
      unique case (st_ff)
        gauge_i2c_pkg::ST_IDLE, gauge_i2c_pkg::ST_IGNORE,
        gauge_i2c_pkg::ST_SLEEP: begin
          nxt_sda_lo = 1'b0;      // Wait for a start
        end
        gauge_i2c_pkg::ST_ADDR, gauge_i2c_pkg::ST_CMD,
        gauge_i2c_pkg::ST_WDATA: begin
          if (scl_rise) begin
            nxt_sh   = {sh_ff[6:0], sda_i};
            nxt_bit  = bit_ff + 3'h1;
            // The eighth bit arms the byte decision
            nxt_full = (bit_ff == 3'h7);
          end else if (scl_fall && full_ff) begin
            // Full byte seen; decide the acknowledge. The bit
            // count alone cannot tell this fall from the one
            // that closes a start, as both see a count of zero
            nxt_full = 1'b0;
            unique case (st_ff)
              gauge_i2c_pkg::ST_ADDR: begin
                nxt_ack = (sh_ff[7:1] == `TGT_ADDR7);
                nxt_rw  = sh_ff[0];
                nxt_st  = gauge_i2c_pkg::ST_ADDR_ACK;
              end
              gauge_i2c_pkg::ST_CMD: begin
                nxt_ack  = (sh_ff <= `MAX_READ_CMD);
                nxt_ptr  = sh_ff;
                nxt_wcnt = '0;
                nxt_st   = gauge_i2c_pkg::ST_CMD_ACK;
              end
              default: begin
                // Refuse surplus bytes and read-only targets
                nxt_ack = (wcnt_ff < WCW'(MAX_WBYTES))
                          && !loc_ro;
                if (nxt_ack) begin
                  nxt_wr   = 1'b1;
                  nxt_wd   = sh_ff;
                  nxt_wcnt = wcnt_ff + WCW'(1);
                end
                nxt_st = gauge_i2c_pkg::ST_WDATA_ACK;
              end
            endcase
            nxt_sda_lo = nxt_ack;
          end
        end
        gauge_i2c_pkg::ST_ADDR_ACK, gauge_i2c_pkg::ST_CMD_ACK,
        gauge_i2c_pkg::ST_WDATA_ACK: begin
          // Ack slot ends at the next falling clock
          if (scl_fall) begin
            nxt_sda_lo = 1'b0;
            nxt_bit    = 3'h0;
            if (!ack_ff) begin
              nxt_st = gauge_i2c_pkg::ST_IGNORE;
            end else if (st_ff == gauge_i2c_pkg::ST_ADDR_ACK) begin
              if (rw_ff) begin
                // Quick or repeated-start read from pointer
                nxt_sh     = loc_rdata;
                nxt_sda_lo = ~loc_rdata[7];
                nxt_st     = gauge_i2c_pkg::ST_RDATA;
              end else begin
                nxt_st = gauge_i2c_pkg::ST_CMD;
              end
            end else begin
              if (st_ff == gauge_i2c_pkg::ST_WDATA_ACK) begin
                nxt_ptr = ptr_ff + 8'h01;
              end
              nxt_st = gauge_i2c_pkg::ST_WDATA;
            end
          end
        end
        gauge_i2c_pkg::ST_RDATA: begin
          // Bit seven went out at load; seven falls shift the rest
          if (scl_fall) begin
            if (bit_ff == 3'h7) begin
              nxt_sda_lo = 1'b0;   // Free data for master ack
              nxt_st     = gauge_i2c_pkg::ST_RDATA_ACK;
            end else begin
              nxt_sh     = {sh_ff[6:0], 1'b0};
              nxt_sda_lo = ~sh_ff[6];
              nxt_bit    = bit_ff + 3'h1;
            end
          end
        end
        gauge_i2c_pkg::ST_RDATA_ACK: begin
          if (scl_rise) begin
            // Pointer moves only on master ack
            nxt_ack = ~sda_i;
            if (!sda_i) begin
              nxt_ptr = ptr_ff + 8'h01;
            end
          end else if (scl_fall) begin
            nxt_bit = 3'h0;
            if (ack_ff) begin
              // Incremental read: next location
              nxt_sh     = loc_rdata;
              nxt_sda_lo = ~loc_rdata[7];
              nxt_st     = gauge_i2c_pkg::ST_RDATA;
            end else begin
              nxt_st = gauge_i2c_pkg::ST_IGNORE;
            end
          end
        end
      endcase
    end
    // Registered straight into the pin enable, so the pin
    // comes from a flop and cannot glitch; the internal
    // drive flag stays as the hold value for the next cycle
    nxt_sda_oe_n = ~nxt_sda_lo;
  end

  // Register stage for the engine
  // Reset leaves the data line released and the pointer at zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff     <= gauge_i2c_pkg::ST_IDLE;
      sh_ff     <= 8'h00;
      bit_ff    <= 3'h0;
      ptr_ff    <= `PTR_RST;
      rw_ff     <= 1'b0;
      ack_ff    <= 1'b0;
      wcnt_ff   <= '0;
      sda_lo_ff <= 1'b0;
      wr_ff     <= 1'b0;
      wd_ff     <= 8'h00;
      slp_ff    <= 1'b0;
      full_ff   <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else begin
      st_ff     <= nxt_st;
      sh_ff     <= nxt_sh;
      bit_ff    <= nxt_bit;
      ptr_ff    <= nxt_ptr;
      rw_ff     <= nxt_rw;
      ack_ff    <= nxt_ack;
      wcnt_ff   <= nxt_wcnt;
      sda_lo_ff <= nxt_sda_lo;
      wr_ff     <= nxt_wr;
      wd_ff     <= nxt_wd;
      slp_ff    <= nxt_slp;
      full_ff   <= nxt_full;
      sda_oe_n_ff <= nxt_sda_oe_n;
    end
  end

  // ========================================================
  // Outputs: clock is never stretched, so it is always released
  // Drive values are tied low: an open-drain pin only pulls
  // down, and its enable alone decides whether it does
  assign scl_o     = 1'b0;
  assign scl_oe_n  = 1'b1;
  assign sda_o     = 1'b0;
  assign sda_oe_n  = sda_oe_n_ff;
  assign loc_addr  = ptr_ff;
  assign loc_wdata = wd_ff;
  assign loc_wr    = wr_ff;
  assign eng_sleep = slp_ff;

endmodule : fuel_gauge_i2c_target

// ---- core/gauge_i2c_consts.svh ----
// Constants for the fuel gauge two-wire target engine
`ifndef GAUGE_I2C_CONSTS_SVH
`define GAUGE_I2C_CONSTS_SVH

// ==========================================================
// Addressing
`define TGT_ADDR7        7'h55
`define TGT_ADDR_WR      8'hAA
`define TGT_ADDR_RD      8'hAB
`define MAX_READ_CMD     8'h7F

// ==========================================================
// Timing
`define CLK_HZ           200000000
`define STUCK_TIMEOUT_MS 2000
`define STUCK_TIMEOUT_CYC (`CLK_HZ / 1000 * `STUCK_TIMEOUT_MS)

// ==========================================================
// Reset values
`define PTR_RST          8'h00

`endif

// ---- core/gauge_i2c_pkg.sv ----
// Types for the fuel gauge two-wire target engine
package gauge_i2c_pkg;

  // ========================================================
  // Bus engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_IGNORE,
    ST_SLEEP
  } eng_state_t;

endpackage : gauge_i2c_pkg
